// file: pcoc_clock_output.sv
// Synthesizer control registers and the clock output pin selector.
// Assumes an analog loop that multiplies and halves the crystal and
// returns that first-stage clock, and timers on this clock domain.
`include "pcoc_params.svh"

module pcoc_clock_output (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  // Crystal reference and analog loop.
  input wire logic xtalClockIn,
  input wire logic stageOneClockIn,
  output logic [4:0] feedbackFactor,
  output logic [7:0] outputDivisionFactor,
  output logic synthPowerDown,
  // Timer overflow pulses.
  input wire logic [3:0] timerOverflow,
  // Clock output pin.
  output logic clockOutputPinOut,
  output logic clockOutputPinOe
);

  // ****************************************************************
  // Reset release
  // ****************************************************************

  logic [1:0] rstPipe_r;
  logic rstSync_n;

  // Releases the asynchronous reset through two flip-flops.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rstPipe_r <= 2'b00;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end

  assign rstSync_n = rstPipe_r[1];

  // ****************************************************************
  // Registers
  // ****************************************************************

  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic [7:0] readData_r;
  logic [7:0] readData_nxt;
  logic [7:0] statusWord;
  logic [3:0] outputSourceSelect;
  logic outputPinGate;
  logic synthPowerDownBit;

  assign outputSourceSelect = ctrl_r[`PCOC_SEL_MSB:`PCOC_SEL_LSB];
  assign outputPinGate = ctrl_r[`PCOC_GATE_BIT];
  assign synthPowerDownBit = ctrl_r[`PCOC_PD_BIT];

  // Decodes writes and answers reads one cycle later; others read zero.
  always_comb begin
    ctrl_nxt = ctrl_r;
    div_nxt = div_r;
    readData_nxt = 8'h00;
    if (regWrite) begin
      if (regAddr == `PCOC_ADDR_CTRL) begin
        ctrl_nxt = regWriteData;
      end
      if (regAddr == `PCOC_ADDR_DIV) begin
        div_nxt = regWriteData;
      end
    end
    if (regRead) begin
      case (regAddr)
        `PCOC_ADDR_CTRL: readData_nxt = ctrl_r;
        `PCOC_ADDR_DIV: readData_nxt = div_r;
        `PCOC_ADDR_STATUS: readData_nxt = statusWord;
        default: readData_nxt = 8'h00;
      endcase
    end
  end

  // Registers the software-visible state.
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ctrl_r <= `PCOC_CTRL_RESET;
      div_r <= `PCOC_DIV_RESET;
      readData_r <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      div_r <= div_nxt;
      readData_r <= readData_nxt;
    end
  end

  assign regReadData = readData_r;

  // ****************************************************************
  // Analog loop settings
  // ****************************************************************

  logic [4:0] feedback_r;
  logic [4:0] feedback_nxt;
  logic powerDown_r;
  logic [7:0] divOut_r;

  // Maps the feedback field to the loop multiplication factor.
  always_comb begin
    case (ctrl_r[`PCOC_FB_MSB:`PCOC_FB_LSB])
      2'b00: feedback_nxt = `PCOC_FB_X23;
      2'b01: feedback_nxt = `PCOC_FB_X27;
      2'b10: feedback_nxt = `PCOC_FB_X28;
      default: feedback_nxt = `PCOC_FB_X23;
    endcase
  end

  // Drives the loop settings from flip-flops; the loop halves the product.
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      feedback_r <= `PCOC_FB_X23;
      powerDown_r <= 1'b0;
      divOut_r <= `PCOC_DIV_RESET;
    end else begin
      feedback_r <= feedback_nxt;
      powerDown_r <= synthPowerDownBit;
      divOut_r <= div_r;
    end
  end

  assign feedbackFactor = feedback_r;
  assign synthPowerDown = powerDown_r;
  assign outputDivisionFactor = divOut_r;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************

  // The first-stage clock is only seen correctly while it runs below
  // half the system clock; faster loops need the analog divider path.
  logic [2:0] xtalSync_r;
  logic [2:0] stageSync_r;
  logic xtalRise;
  logic stageRise;

  // Passes both foreign clocks through two flip-flops, then a third for edges.
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      xtalSync_r <= 3'b000;
      stageSync_r <= 3'b000;
    end else begin
      xtalSync_r <= {xtalSync_r[1:0], xtalClockIn};
      stageSync_r <= {stageSync_r[1:0], stageOneClockIn};
    end
  end

  assign xtalRise = xtalSync_r[1] && !xtalSync_r[2];
  assign stageRise = stageSync_r[1] && !stageSync_r[2];

  // ****************************************************************
  // Second stage and crystal dividers
  // ****************************************************************

  logic synthesizedClock;
  logic [2:0] xtalCount_r;
  logic [2:0] xtalCount_nxt;

  // Divides the first-stage clock by the output division factor.
  pcoc_stage_divider u_pcoc_stage_divider (
    .clock(clock),
    .rstSync_n(rstSync_n),
    .enable(!powerDown_r),
    .divisor(div_r),
    .tick(stageRise),
    .synthesizedClock(synthesizedClock)
  );

  // Counts crystal edges; its bits are the crystal divided by 2, 4, 8.
  always_comb begin
    xtalCount_nxt = xtalCount_r;
    if (xtalRise) begin
      xtalCount_nxt = xtalCount_r + 3'b001;
    end
  end

  // Registers the crystal divider.
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      xtalCount_r <= 3'b000;
    end else begin
      xtalCount_r <= xtalCount_nxt;
    end
  end

  // ****************************************************************
  // Timer overflow toggles
  // ****************************************************************

  logic [3:0] toggle_r;

  // One toggle flip-flop per timer, flipping on each overflow pulse.
  genvar t;
  generate
    for (t = 0; t < 4; t++) begin : gTimer
      logic toggleNxt;
      always_comb begin
        toggleNxt = toggle_r[t] ^ timerOverflow[t];
      end
      always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
          toggle_r[t] <= 1'b0;
        end else begin
          toggle_r[t] <= toggleNxt;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Output pin selector
  // ****************************************************************

  logic pinOut_r;
  logic pinOut_nxt;
  logic pinOe_r;
  logic pinOe_nxt;
  logic srcLevel;

  // Picks the source level named by the select field.
  always_comb begin
    case (outputSourceSelect)
      pcoc_pkg::SEL_SYNTH: srcLevel = synthesizedClock;
      pcoc_pkg::SEL_LOW: srcLevel = 1'b0;
      pcoc_pkg::SEL_HIGH: srcLevel = 1'b1;
      pcoc_pkg::SEL_XTAL: srcLevel = xtalSync_r[1];
      pcoc_pkg::SEL_XTAL_D2: srcLevel = xtalCount_r[0];
      pcoc_pkg::SEL_XTAL_D4: srcLevel = xtalCount_r[1];
      pcoc_pkg::SEL_XTAL_D8: srcLevel = xtalCount_r[2];
      pcoc_pkg::SEL_TMR0: srcLevel = toggle_r[0];
      pcoc_pkg::SEL_TMR1: srcLevel = toggle_r[1];
      pcoc_pkg::SEL_TMR2: srcLevel = toggle_r[2];
      pcoc_pkg::SEL_TMR3: srcLevel = toggle_r[3];
      default: srcLevel = 1'b0;
    endcase
  end

  // Releases the pin at code 0, otherwise drives the gated source.
  always_comb begin
    pinOe_nxt = (outputSourceSelect != pcoc_pkg::SEL_IO);
    pinOut_nxt = pinOe_nxt && outputPinGate && srcLevel;
  end

  // Registers the pin drive.
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pinOut_r <= 1'b0;
      pinOe_r <= 1'b0;
    end else begin
      pinOut_r <= pinOut_nxt;
      pinOe_r <= pinOe_nxt;
    end
  end

  assign clockOutputPinOut = pinOut_r;
  assign clockOutputPinOe = pinOe_r;

  // Reports pin drive, synthesizer activity and the timer toggles.
  assign statusWord = {pinOut_r, pinOe_r, !powerDown_r, synthesizedClock,
                       toggle_r};

  // ****************************************************************
  // Assertions
  // ****************************************************************

  property p_fbCode10;
    @(posedge clock) disable iff (!rstSync_n)
      (ctrl_r[1:0] == 2'b10) |=> (feedbackFactor == `PCOC_FB_X28);
  endproperty
  a_fbCode10: assert property (p_fbCode10)
    else $error("Feedback code 10 did not give factor 28.");

  property p_fbCode11;
    @(posedge clock) disable iff (!rstSync_n)
      (ctrl_r[1:0] == 2'b11) |=> (feedbackFactor == `PCOC_FB_X23);
  endproperty
  a_fbCode11: assert property (p_fbCode11)
    else $error("Feedback code 11 did not give factor 23.");

  property p_pinReleased;
    @(posedge clock) disable iff (!rstSync_n)
      (ctrl_r[7:4] == 4'h0) |=> !clockOutputPinOe;
  endproperty
  a_pinReleased: assert property (p_pinReleased)
    else $error("Pin was driven while released to I/O.");

  property p_holdLow;
    @(posedge clock) disable iff (!rstSync_n)
      (ctrl_r[7:3] == 5'b00101) |=> (clockOutputPinOe && !clockOutputPinOut);
  endproperty
  a_holdLow: assert property (p_holdLow)
    else $error("Pin not held low for code 2.");

  property p_holdHigh;
    @(posedge clock) disable iff (!rstSync_n)
      (ctrl_r[7:3] == 5'b00111) |=> (clockOutputPinOe && clockOutputPinOut);
  endproperty
  a_holdHigh: assert property (p_holdHigh)
    else $error("Pin not held high for code 3.");

  property p_gateOff;
    @(posedge clock) disable iff (!rstSync_n)
      (!ctrl_r[3] && ctrl_r[7:4] != 4'h0) |=> !clockOutputPinOut;
  endproperty
  a_gateOff: assert property (p_gateOff)
    else $error("Pin showed a clock with the gate closed.");

  property p_timerToggle;
    @(posedge clock) disable iff (!rstSync_n)
      (timerOverflow[1] && ctrl_r[7:3] == 5'b10011)
        |=> ##1 (clockOutputPinOut != $past(clockOutputPinOut));
  endproperty
  a_timerToggle: assert property (p_timerToggle)
    else $error("Timer 1 overflow did not toggle the pin.");

  property p_powerDown;
    @(posedge clock) disable iff (!rstSync_n)
      ctrl_r[2] [*2] |=> (synthPowerDown && !synthesizedClock);
  endproperty
  a_powerDown: assert property (p_powerDown)
    else $error("Synthesizer ran while powered down.");

  property p_divWrite;
    @(posedge clock) disable iff (!rstSync_n)
      (regWrite && regAddr == `PCOC_ADDR_DIV) |=> ##1
        (outputDivisionFactor == $past(regWriteData, 2));
  endproperty
  a_divWrite: assert property (p_divWrite)
    else $error("Division factor write did not reach the loop.");

  property p_divReserved;
    @(posedge clock) disable iff (!rstSync_n)
      (div_r < `PCOC_DIV_MIN) [*2] |-> !synthesizedClock;
  endproperty
  a_divReserved: assert property (p_divReserved)
    else $error("Reserved division factor produced a clock.");

endmodule : pcoc_clock_output

// file: pcoc_params.svh
// Constants of the synthesizer control and clock output selector.
// Assumes inclusion by its bare name from every file that needs them.
`ifndef PCOC_PARAMS_SVH
`define PCOC_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PCOC_ADDR_CTRL 8'h3d
`define PCOC_ADDR_DIV 8'h3e
`define PCOC_ADDR_STATUS 8'h70

// ****************************************************************
// Control register fields
// ****************************************************************
`define PCOC_SEL_MSB 7
`define PCOC_SEL_LSB 4
`define PCOC_GATE_BIT 3
`define PCOC_PD_BIT 2
`define PCOC_FB_MSB 1
`define PCOC_FB_LSB 0

// ****************************************************************
// Reset values and factors
// ****************************************************************
`define PCOC_CTRL_RESET 8'h00
`define PCOC_DIV_RESET 8'h08
`define PCOC_DIV_MIN 8'h08
`define PCOC_FB_X23 5'h17
`define PCOC_FB_X27 5'h1b
`define PCOC_FB_X28 5'h1c

`endif

// file: pcoc_pkg.sv
// Types shared by the synthesizer control and clock output selector.
// Assumes the constants header is included where offsets are needed.
package pcoc_pkg;

  // Codes of the output source select field.
  typedef enum logic [3:0] {
    SEL_IO = 4'b0000,
    SEL_SYNTH = 4'b0001,
    SEL_LOW = 4'b0010,
    SEL_HIGH = 4'b0011,
    SEL_XTAL = 4'b0100,
    SEL_XTAL_D2 = 4'b0101,
    SEL_XTAL_D4 = 4'b0110,
    SEL_XTAL_D8 = 4'b0111,
    SEL_TMR0 = 4'b1000,
    SEL_TMR1 = 4'b1001,
    SEL_TMR2 = 4'b1010,
    SEL_TMR3 = 4'b1011
  } pcoc_sel_t;

endpackage : pcoc_pkg

// file: pcoc_stage_divider.sv
// Second synthesizer stage: divides first-stage ticks by a byte factor.
// Assumes tick is a one-cycle pulse on the same clock as this module.
`include "pcoc_params.svh"

module pcoc_stage_divider (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstSync_n,
  // Control.
  input wire logic enable,
  input wire logic [7:0] divisor,
  input wire logic tick,
  // Divided clock level.
  output logic synthesizedClock
);

  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic level_r;
  logic level_nxt;

  // Counts ticks modulo the divisor; stops when off or reserved factor.
  always_comb begin
    count_nxt = count_r;
    level_nxt = level_r;
    if (!enable || (divisor < `PCOC_DIV_MIN)) begin
      count_nxt = 8'h00;
      level_nxt = 1'b0;
    end else if (tick) begin
      if (count_r >= divisor - 8'h01) begin
        count_nxt = 8'h00;
      end else begin
        count_nxt = count_r + 8'h01;
      end
      level_nxt = (count_nxt < {1'b0, divisor[7:1]});
    end
  end

  // Registers the divider state.
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      count_r <= 8'h00;
      level_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      level_r <= level_nxt;
    end
  end

  assign synthesizedClock = level_r;

endmodule : pcoc_stage_divider

// file: tb_pcoc_clock_output.sv
// Self-checking testbench of the synthesizer control and clock output pin.
// Assumes the constants header and the design files are compiled first.
`include "pcoc_params.svh"

module tb_pcoc_clock_output;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clock;
  logic reset_n;
  logic [7:0] regAddr;
  logic [7:0] regWriteData;
  logic regWrite;
  logic regRead;
  logic [7:0] regReadData;
  logic xtalClockIn;
  logic stageOneClockIn;
  logic [4:0] feedbackFactor;
  logic [7:0] outputDivisionFactor;
  logic synthPowerDown;
  logic [3:0] timerOverflow;
  logic clockOutputPinOut;
  logic clockOutputPinOe;
  int err_count;
  int n_checks;
  logic [7:0] rdata;
  logic pinBefore;
  int edges;
  logic [7:0] pinBits;
  logic [7:0] fbExp [4] = '{8'h17, 8'h1b, 8'h1c, 8'h17};

  pcoc_clock_output u_pcoc_clock_output (
    .clock(clock), .reset_n(reset_n), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .xtalClockIn(xtalClockIn),
    .stageOneClockIn(stageOneClockIn), .feedbackFactor(feedbackFactor),
    .outputDivisionFactor(outputDivisionFactor),
    .synthPowerDown(synthPowerDown), .timerOverflow(timerOverflow),
    .clockOutputPinOut(clockOutputPinOut),
    .clockOutputPinOe(clockOutputPinOe)
  );

  // Pin enable and pin value side by side, as one byte for compares.
  assign pinBits = {6'h0, clockOutputPinOe, clockOutputPinOut};

  // ****************************************************************
  // Clocks
  // ****************************************************************
  // System clock of 5 ns, crystal near 27.12 MHz, first stage at 25 MHz.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    xtalClockIn = 1'b0;
    forever #18.436 xtalClockIn = ~xtalClockIn;
  end
  initial begin
    stageOneClockIn = 1'b0;
    forever #20 stageOneClockIn = ~stageOneClockIn;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // One write cycle on the register port.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr

  // One read cycle; the data are taken in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regReadData;
  endtask : rd

  // Lets a control write reach the pin and the loop outputs.
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask : settle

  // Compares a byte value.
  task automatic check(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // Compares a count of pin edges against a window.
  task automatic checkRange(input string nm, input int lo, input int hi,
                            input int g);
    n_checks++;
    if (g < lo || g > hi) begin
      err_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : checkRange

  // Counts rising edges of the pin over a number of clock cycles.
  task automatic countRises(input int cycles, output int n);
    logic prev;
    n = 0;
    @(posedge clock);
    prev = clockOutputPinOut;
    repeat (cycles) begin
      @(posedge clock);
      if (clockOutputPinOut === 1'b1 && prev === 1'b0) n++;
      prev = clockOutputPinOut;
    end
  endtask : countRises

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // Tests
  // ****************************************************************
  // Watchdog that cuts a hang short.
  initial begin
    #300us;
    err_count++;
    end_of_test();
  end

  // Main sequence of tests.
  initial begin
    err_count = 0;
    n_checks = 0;
    reset_n = 1'b0;
    regAddr = 8'h00;
    regWriteData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    timerOverflow = 4'h0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    #1 check("loop factor", 8'h17, {3'h0, feedbackFactor});
    check("pin enable", 8'h00, {7'h0, clockOutputPinOe});
    repeat (3) @(posedge clock);
    rd(`PCOC_ADDR_CTRL, rdata);
    check("control reset", 8'h00, rdata);
    rd(`PCOC_ADDR_DIV, rdata);
    check("divider reset", 8'h08, rdata);
    $display("reset values done");

    wr(`PCOC_ADDR_DIV, 8'hfe);
    wr(8'h3f, 8'h55);
    rd(`PCOC_ADDR_DIV, rdata);
    check("divider", 8'hfe, rdata);
    check("divider copy", 8'hfe, outputDivisionFactor);
    rd(8'h3f, rdata);
    check("unmapped", 8'h00, rdata);
    rd(`PCOC_ADDR_CTRL, rdata);
    check("control kept", 8'h00, rdata);
    $display("register access done");

    for (int i = 0; i < 4; i++) begin
      wr(`PCOC_ADDR_CTRL, {6'h00, 2'(i)});
      settle();
      check("loop factor", fbExp[i], {3'h0, feedbackFactor});
    end
    wr(`PCOC_ADDR_CTRL, 8'h04);
    settle();
    check("power down", 8'h01, {7'h0, synthPowerDown});
    $display("loop control done");

    wr(`PCOC_ADDR_CTRL, 8'h08);
    settle();
    check("released", 8'h00, {7'h0, clockOutputPinOe});
    wr(`PCOC_ADDR_CTRL, 8'h28);
    settle();
    check("held low", 8'h02, pinBits);
    wr(`PCOC_ADDR_CTRL, 8'h38);
    settle();
    check("held high", 8'h03, pinBits);
    wr(`PCOC_ADDR_CTRL, 8'h30);
    settle();
    check("gated off", 8'h02, pinBits);
    $display("fixed levels done");

    for (int i = 0; i < 4; i++) begin
      wr(`PCOC_ADDR_CTRL, {4'(4 + i), 4'h8});
      settle();
      countRises(442, edges);
      checkRange("xtal rises", (60 >> i) - 2, (60 >> i) + 2, edges);
    end
    $display("crystal sources done");

    for (int i = 0; i < 4; i++) begin
      wr(`PCOC_ADDR_CTRL, {4'(8 + i), 4'h8});
      settle();
      pinBefore = clockOutputPinOut;
      @(posedge clock);
      timerOverflow <= 4'(1 << i);
      @(posedge clock);
      timerOverflow <= 4'h0;
      repeat (2) @(posedge clock);
      #1 check("timer toggle", {6'h0, 1'b1, ~pinBefore}, pinBits);
    end
    $display("timer toggles done");

    wr(`PCOC_ADDR_DIV, 8'h08);
    wr(`PCOC_ADDR_CTRL, 8'h18);
    settle();
    countRises(640, edges);
    checkRange("synth div 8", 9, 11, edges);
    wr(`PCOC_ADDR_DIV, 8'h10);
    settle();
    countRises(640, edges);
    checkRange("synth div 16", 4, 6, edges);
    wr(`PCOC_ADDR_DIV, 8'h04);
    settle();
    countRises(640, edges);
    checkRange("synth reserved", 0, 0, edges);
    wr(`PCOC_ADDR_DIV, 8'h08);
    wr(`PCOC_ADDR_CTRL, 8'h1c);
    settle();
    countRises(640, edges);
    checkRange("synth powered down", 0, 0, edges);
    // Status ignores writes; shows pin, stopped loop and all four toggles.
    wr(`PCOC_ADDR_STATUS, 8'hff);
    rd(`PCOC_ADDR_STATUS, rdata);
    check("status", 8'h4f, rdata);
    $display("synthesized clock done");
    end_of_test();
  end

endmodule : tb_pcoc_clock_output
